// [rtl/ssp_pkg.sv]
package ssp_pkg;
    // Register addresses (index values, byte units not used on this port)
    localparam logic [2:0] ADDR_RX_STATUS = 3'h0;
    localparam logic [2:0] ADDR_TX_BUFFER = 3'h1;
    localparam logic [2:0] ADDR_TX_STATUS = 3'h2;
    localparam logic [2:0] ADDR_BAUD_CTRL = 3'h3;
    localparam logic [2:0] ADDR_DIV_HIGH = 3'h4;
    localparam logic [2:0] ADDR_DIV_LOW = 3'h5;
    localparam logic [2:0] ADDR_RX_BUFFER = 3'h6;
    localparam logic [2:0] ADDR_IRQ_CTRL = 3'h7;
    // Receive status/control bits
    localparam int RS_PORT_EN = 7;
    localparam int RS_RX9_SEL = 6;
    localparam int RS_SINGLE_RX = 5;
    localparam int RS_CONT_RX = 4;
    localparam int RS_ADDR_DET = 3;
    localparam int RS_FRAME_ERR = 2;
    localparam int RS_OVERRUN = 1;
    localparam int RS_RX9_BIT = 0;
    // Transmit status/control bits
    localparam int TS_CLK_SRC = 7;
    localparam int TS_TX9_SEL = 6;
    localparam int TS_TX_EN = 5;
    localparam int TS_SYNC = 4;
    localparam int TS_BREAK = 3;
    localparam int TS_HIGH_RATE = 2;
    localparam int TS_SHIFT_EMPTY = 1;
    localparam int TS_TX9_BIT = 0;
    // Interrupt control bits (flags and enables)
    localparam int IC_GLOBAL_EN = 7;
    localparam int IC_PERIPH_EN = 6;
    localparam int IC_RX_IE = 5;
    localparam int IC_TX_IE = 4;
    localparam int IC_RX_FULL = 1;
    localparam int IC_TX_EMPTY = 0;
    // Reset values and word lengths
    localparam logic [7:0] RX_STATUS_RST = 8'h00;
    localparam logic [7:0] TX_STATUS_RST = 8'h02;
    localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [3:0] WORD_BITS_8 = 4'h8;
    localparam logic [3:0] WORD_BITS_9 = 4'h9;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ssp_bus_req_t;

    typedef enum logic [1:0] {
        SSP_TX_IDLE = 2'b00,
        SSP_TX_SHIFT = 2'b01
    } ssp_tx_state_t;
endpackage : ssp_pkg

// [rtl/ssp_slave.sv]
// Function
// R1 - Slave behaves like master except listed cases
// R2 - First buffered word moves to shifter immediately
// R3 - Second word waits; empty flag stays clear
// R4 - After shift-out, load second word, set flag
// R5 - Transmit empty interrupt wakes chip if enabled
// R6 - Software selects sync, port enable, external clock
// R7 - Software clears both receive enables first
// R8 - Nine-bit transmit sends selected ninth bit
// R9 - Transmit starts only on load while enabled
// R10 - Single receive enable ignored in slave mode
// R11 - Continuous receive works during sleep or idle
// R12 - Completed word moves into receive buffer
// R13 - Receive interrupt wakes chip if enabled
// R14 - Wake with global enable branches to vector
// R15 - Full flag set; interrupt only when enabled
// R16 - Ninth bit and errors shown in status
// R17 - Receive buffer read returns eight data bits
// R18 - Clearing continuous receive clears error
// R19 - Software sets global and peripheral enables
// R20 - Nine-bit receive captures nine bits
// R21 - Shift clock comes from external clock pin
// R22 - Read-only shift empty status bit
// R23 - Ninth bit captured with data byte
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module ssp_slave (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire ssp_pkg::ssp_bus_req_t i_bus,
    output logic [7:0] o_rdata,
    input wire logic i_serial_clock_pin,
    input wire logic i_data_pin,
    output logic o_data_pin,
    output logic o_data_oe,
    input wire logic i_low_power,
    output logic o_wake,
    output logic o_irq_vector
);
    import ssp_pkg::*;

    logic [7:0] rx_status_r;
    logic [7:0] tx_status_r;
    logic [7:0] irq_ctrl_r;
    logic [7:0] baud_r;
    logic [7:0] div_high_r;
    logic [7:0] div_low_r;
    logic [7:0] tx_buffer_reg_r;
    logic tx_buf_full_r;
    logic [8:0] tx_shift_reg_r;
    logic [3:0] tx_cnt_r;
    ssp_tx_state_t tx_state_r;
    logic [8:0] rx_shift_reg_r;
    logic [3:0] rx_cnt_r;
    logic [7:0] rx_buffer_reg_r;
    logic rx_full_r;
    logic [2:0] ck_sync_r;
    logic [1:0] dat_sync_r;

    // Link clock and data synchronisers
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ck_sync_r <= 3'h0;
            dat_sync_r <= 2'h0;
        end else if (i_ce) begin
            ck_sync_r <= {ck_sync_r[1:0], i_serial_clock_pin}; // R21
            dat_sync_r <= {dat_sync_r[0], i_data_pin};
        end
    end

    logic ck_rise;
    logic ck_fall;
    logic slave_on;
    logic rx_run;
    logic tx_run;
    logic [3:0] tx_bits;
    logic [3:0] rx_bits;
    logic wr_txbuf;
    logic rd_rxbuf;
    logic rx_done;
    logic tx_done;
    logic tx_load;
    logic [8:0] rx_word;

    // Word as it stands once the bit now sampled is added
    always_comb begin
        rx_word = rx_shift_reg_r;
        rx_word[rx_cnt_r] = dat_sync_r[1];
    end

    assign ck_rise = ck_sync_r[1] & ~ck_sync_r[2];
    assign ck_fall = ~ck_sync_r[1] & ck_sync_r[2];
    // External clock: clock source select clear
    assign slave_on = rx_status_r[RS_PORT_EN] & tx_status_r[TS_SYNC]
        & ~tx_status_r[TS_CLK_SRC]; // R1 R21
    // Only continuous receive enable matters
    assign rx_run = slave_on & rx_status_r[RS_CONT_RX]; // R10 R11
    assign tx_run = slave_on & tx_status_r[TS_TX_EN];
    assign tx_bits = tx_status_r[TS_TX9_SEL] ? WORD_BITS_9 : WORD_BITS_8;
    assign rx_bits = rx_status_r[RS_RX9_SEL] ? WORD_BITS_9 : WORD_BITS_8;
    assign wr_txbuf = i_bus.wr & (i_bus.addr == ADDR_TX_BUFFER);
    assign rd_rxbuf = i_bus.rd & (i_bus.addr == ADDR_RX_BUFFER);
    assign rx_done = rx_run & ck_fall & (rx_cnt_r == rx_bits - 4'h1);
    assign tx_done = (tx_state_r == SSP_TX_SHIFT) & ck_rise
        & (tx_cnt_r == tx_bits - 4'h1);
    // Buffered word enters the shifter when it is free
    assign tx_load = tx_run & tx_buf_full_r
        & ((tx_state_r == SSP_TX_IDLE) | tx_done); // R2 R4

    // Receive status/control register
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_status_r <= RX_STATUS_RST;
        end else if (i_ce) begin
            if (i_bus.wr && i_bus.addr == ADDR_RX_STATUS) begin
                rx_status_r[7:3] <= i_bus.wdata[7:3];
                if (!i_bus.wdata[RS_CONT_RX]) begin
                    rx_status_r[RS_OVERRUN] <= 1'b0; // R18
                    rx_status_r[RS_FRAME_ERR] <= 1'b0; // R18
                end
            end
            // Word completed while buffer still full
            if (rx_done && rx_full_r && !rd_rxbuf) begin
                rx_status_r[RS_OVERRUN] <= 1'b1; // R16
            end
            if (rx_done && !(rx_full_r && !rd_rxbuf)) begin
                rx_status_r[RS_RX9_BIT] <= rx_status_r[RS_RX9_SEL]
                    & rx_word[8]; // R23 R20
            end
        end
    end

    // Transmit status/control register
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_status_r <= TX_STATUS_RST;
        end else if (i_ce) begin
            if (i_bus.wr && i_bus.addr == ADDR_TX_STATUS) begin
                tx_status_r[7:2] <= i_bus.wdata[7:2];
                tx_status_r[TS_TX9_BIT] <= i_bus.wdata[TS_TX9_BIT];
            end
            // Shift empty is read-only, no interrupt
            if (tx_load) begin
                tx_status_r[TS_SHIFT_EMPTY] <= 1'b0; // R22
            end else if (tx_done) begin
                tx_status_r[TS_SHIFT_EMPTY] <= 1'b1; // R22
            end
        end
    end

    // Interrupt control: enables only; flags come from the buffer full bits
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_ctrl_r <= IRQ_CTRL_RST;
        end else if (i_ce) begin
            if (i_bus.wr && i_bus.addr == ADDR_IRQ_CTRL) begin
                irq_ctrl_r[7:4] <= i_bus.wdata[7:4]; // R19
            end
        end
    end

    // Spare registers kept for software
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            baud_r <= BAUD_RST;
            div_high_r <= BAUD_RST;
            div_low_r <= BAUD_RST;
        end else if (i_ce && i_bus.wr) begin
            if (i_bus.addr == ADDR_BAUD_CTRL) begin
                baud_r <= i_bus.wdata;
            end
            if (i_bus.addr == ADDR_DIV_HIGH) begin
                div_high_r <= i_bus.wdata;
            end
            if (i_bus.addr == ADDR_DIV_LOW) begin
                div_low_r <= i_bus.wdata;
            end
        end
    end

    // Transmit buffer; empty flag is its inverse
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_buffer_reg_r <= 8'h00;
            tx_buf_full_r <= 1'b0;
        end else if (i_ce) begin
            if (wr_txbuf && tx_status_r[TS_TX_EN]) begin
                tx_buffer_reg_r <= i_bus.wdata; // R9
                tx_buf_full_r <= 1'b1; // R3
            end else if (tx_load) begin
                tx_buf_full_r <= 1'b0; // R4
            end
        end
    end

    // Transmit shifter, changes data on rising edge
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_state_r <= SSP_TX_IDLE;
            tx_shift_reg_r <= 9'h000;
            tx_cnt_r <= 4'h0;
        end else if (i_ce) begin
            case (tx_state_r)
                SSP_TX_IDLE: begin
                    if (tx_load) begin
                        tx_shift_reg_r <= {tx_status_r[TS_TX9_BIT],
                            tx_buffer_reg_r}; // R2 R8
                        tx_cnt_r <= 4'h0;
                        tx_state_r <= SSP_TX_SHIFT;
                    end
                end
                SSP_TX_SHIFT: begin
                    if (!tx_run) begin
                        tx_state_r <= SSP_TX_IDLE;
                    end else if (tx_load) begin
                        tx_shift_reg_r <= {tx_status_r[TS_TX9_BIT],
                            tx_buffer_reg_r}; // R4 R8
                        tx_cnt_r <= 4'h0;
                    end else if (tx_done) begin
                        tx_state_r <= SSP_TX_IDLE;
                    end else if (ck_rise) begin
                        tx_shift_reg_r <= {1'b0, tx_shift_reg_r[8:1]};
                        tx_cnt_r <= tx_cnt_r + 4'h1;
                    end
                end
                default: begin
                    tx_state_r <= SSP_TX_IDLE;
                end
            endcase
        end
    end

    // Receive shifter samples on falling edge
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_shift_reg_r <= 9'h000;
            rx_cnt_r <= 4'h0;
        end else if (i_ce) begin
            if (!rx_run) begin
                rx_cnt_r <= 4'h0;
            end else if (ck_fall) begin
                rx_shift_reg_r[rx_cnt_r] <= dat_sync_r[1]; // R20
                rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_r + 4'h1; // R11
            end
        end
    end

    // Receive buffer and full flag; set wins over read
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_buffer_reg_r <= 8'h00;
            rx_full_r <= 1'b0;
        end else if (i_ce) begin
            if (rx_done && !(rx_full_r && !rd_rxbuf)) begin
                rx_buffer_reg_r <= rx_word[7:0]; // R12 R23
                rx_full_r <= 1'b1; // R15
            end else if (rd_rxbuf) begin
                rx_full_r <= 1'b0;
            end
        end
    end

    // Read data, one cycle after strobe
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            o_rdata <= 8'h00;
            if (i_bus.rd) begin
                case (i_bus.addr)
                    ADDR_RX_STATUS: o_rdata <= rx_status_r; // R16
                    ADDR_TX_STATUS: o_rdata <= tx_status_r; // R22
                    ADDR_BAUD_CTRL: o_rdata <= baud_r;
                    ADDR_DIV_HIGH: o_rdata <= div_high_r;
                    ADDR_DIV_LOW: o_rdata <= div_low_r;
                    ADDR_RX_BUFFER: o_rdata <= rx_buffer_reg_r; // R17
                    ADDR_IRQ_CTRL: o_rdata <= {irq_ctrl_r[7:4], 2'b00,
                        rx_full_r, ~tx_buf_full_r};
                    default: o_rdata <= 8'h00;
                endcase
            end
        end
    end

    logic tx_irq;
    logic rx_irq;
    assign tx_irq = irq_ctrl_r[IC_TX_IE] & ~tx_buf_full_r; // R5
    assign rx_irq = irq_ctrl_r[IC_RX_IE] & rx_full_r; // R13 R15

    // Pins, wake and vector request
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data_pin <= 1'b0;
            o_data_oe <= 1'b0;
            o_wake <= 1'b0;
            o_irq_vector <= 1'b0;
        end else if (i_ce) begin
            o_data_pin <= tx_shift_reg_r[0];
            o_data_oe <= tx_state_r == SSP_TX_SHIFT;
            o_wake <= i_low_power & (tx_irq | rx_irq); // R5 R13
            o_irq_vector <= (tx_irq | rx_irq) & irq_ctrl_r[IC_GLOBAL_EN]
                & irq_ctrl_r[IC_PERIPH_EN]; // R14
        end
    end
endmodule : ssp_slave

// [tb/ssp_slave_asserts.sv]
`timescale 1ns/1ps
module ssp_slave_chk
    import ssp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire ssp_pkg::ssp_bus_req_t i_bus,
    input wire logic [7:0] o_rdata,
    input wire logic i_serial_clock_pin,
    input wire logic i_data_pin,
    input wire logic o_data_pin,
    input wire logic o_data_oe,
    input wire logic i_low_power,
    input wire logic o_wake,
    input wire logic o_irq_vector
);
    logic [7:0] ts_r, rs_r, ic_r;
    logic [3:0] rise_r;
    logic clk_d_r;
    logic wr_c, txw_c, go_c;
    assign wr_c = i_bus.wr && i_ce;
    assign txw_c = wr_c && i_bus.addr == ADDR_TX_BUFFER;
    assign go_c = ts_r[TS_TX_EN] && ts_r[TS_SYNC] && !ts_r[TS_CLK_SRC]
        && rs_r[RS_PORT_EN];
    // Shadow of control bytes and cycles since a link clock rise
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ts_r <= 8'h00;
            rs_r <= 8'h00;
            ic_r <= 8'h00;
            clk_d_r <= 1'b0;
            rise_r <= 4'h0;
        end else begin
            if (wr_c && i_bus.addr == ADDR_TX_STATUS)
                ts_r <= i_bus.wdata;
            if (wr_c && i_bus.addr == ADDR_RX_STATUS)
                rs_r <= i_bus.wdata;
            if (wr_c && i_bus.addr == ADDR_IRQ_CTRL)
                ic_r <= i_bus.wdata;
            clk_d_r <= i_serial_clock_pin;
            rise_r <= (i_serial_clock_pin && !clk_d_r) ? 4'h0
                : rise_r + {3'h0, rise_r != 4'hF};
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    rdata_idle_a: assert property (!(i_bus.rd && i_ce) |=> o_rdata == 8'h00)
        else $error("read data outside read slot");
    tx_ignore_a: assert property (txw_c && !ts_r[TS_TX_EN] && !o_data_oe
        |=> !o_data_oe) else $error("load while disabled started shift");
    tx_start_a: assert property (txw_c && go_c && !o_data_oe
        |-> ##[1:3] o_data_oe) else $error("load did not start shift");
    irq_gate_a: assert property ((!(ic_r[7] && ic_r[6])) [*2]
        |-> !o_irq_vector) else $error("vector without global enables");
    wake_gate_a: assert property (!i_low_power [*2] |-> !o_wake)
        else $error("wake outside low power");
    pin_timing_a: assert property (o_data_oe && $past(o_data_oe)
        && $changed(o_data_pin) |-> rise_r <= 4'h6)
        else $error("data changed without link clock rise");
    shift_busy_a: assert property (i_bus.rd && i_ce
        && i_bus.addr == ADDR_TX_STATUS && o_data_oe
        |=> !o_rdata[TS_SHIFT_EMPTY] || !o_data_oe)
        else $error("shift empty while busy");
    reset_quiet_a: assert property ($rose(i_nrst)
        |-> !o_data_oe && !o_wake && !o_irq_vector)
        else $error("outputs active after reset");
    cover property (o_wake);
    cover property (o_irq_vector);
    cover property (o_data_oe && $rose(o_data_pin));
endmodule : ssp_slave_chk

bind ssp_slave ssp_slave_chk chk_u (.i_clock, .i_nrst, .i_ce, .i_bus,
    .o_rdata, .i_serial_clock_pin, .i_data_pin, .o_data_pin, .o_data_oe,
    .i_low_power, .o_wake, .o_irq_vector);

// [tb/ssp_master_model.sv]
`timescale 1ns/1ps
module ssp_master_model (
    input wire logic i_dev_data,
    output logic o_sclk,
    output logic o_sdata
);
    initial begin
        o_sclk = 1'b0;
        o_sdata = 1'b1;
    end
    // One frame, bit 0 first; clock rests low between frames
    task automatic frame(input int n, input logic [8:0] w,
        output logic [8:0] got);
        got = 9'h000;
        for (int i = 0; i < n; i++) begin
            o_sdata = w[i];
            #31;
            got[i] = i_dev_data;
            #31 o_sclk = 1'b1;
            #32 o_sclk = 1'b0;
            // Data held past the falling edge the slave samples on
            #31;
        end
        #31 o_sdata = ~o_sdata;
    endtask : frame
endmodule : ssp_master_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import ssp_pkg::*;
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic i_low_power = 1'b0;
    ssp_bus_req_t bus = '0;
    logic [7:0] rdata, d;
    logic sclk, sdata, dpin, oe, wake, irqv;
    logic [8:0] got;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    always #5 i_clock = ~i_clock;
    ssp_slave dut_u (.i_clock, .i_nrst, .i_ce(1'b1), .i_bus(bus),
        .o_rdata(rdata), .i_serial_clock_pin(sclk), .i_data_pin(sdata),
        .o_data_pin(dpin), .o_data_oe(oe), .i_low_power,
        .o_wake(wake), .o_irq_vector(irqv));
    ssp_master_model mst_u (.i_dev_data(dpin), .o_sclk(sclk),
        .o_sdata(sdata));
    task automatic check(string n, logic [8:0] seen, logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic wr(logic [2:0] a, logic [7:0] v);
        @(posedge i_clock);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge i_clock);
        bus <= '0;
    endtask : wr
    task automatic rdchk(string n, logic [2:0] a, logic [7:0] e);
        @(posedge i_clock);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_clock);
        bus <= '0;
        #1 d = rdata;
        check(n, {1'b0, d}, {1'b0, e});
    endtask : rdchk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge i_clock);
        i_nrst <= 1'b1;
        rdchk("tx status rst", ADDR_TX_STATUS, TX_STATUS_RST);
        rdchk("rx status rst", ADDR_RX_STATUS, RX_STATUS_RST);
        wr(ADDR_TX_BUFFER, 8'h66);
        repeat (4) @(posedge i_clock);
        check("oe disabled", {8'h00, oe}, 9'h000);
        wr(ADDR_RX_STATUS, 8'h80);
        wr(ADDR_TX_STATUS, 8'h30);
        wr(ADDR_IRQ_CTRL, 8'hD0);
        i_low_power <= 1'b1;
        wr(ADDR_TX_BUFFER, 8'h55);
        wr(ADDR_TX_BUFFER, 8'hA3);
        rdchk("empty held", ADDR_IRQ_CTRL, 8'hD0);
        rdchk("shift busy", ADDR_TX_STATUS, 8'h30);
        check("wake early", {8'h00, wake}, 9'h000);
        mst_u.frame(8, 9'h000, got);
        check("first word", got, 9'h055);
        repeat (6) @(posedge i_clock);
        check("wake tx", {8'h00, wake}, 9'h001);
        check("vector tx", {8'h00, irqv}, 9'h001);
        rdchk("empty set", ADDR_IRQ_CTRL, 8'hD1);
        mst_u.frame(8, 9'h000, got);
        check("second word", got, 9'h0A3);
        repeat (6) @(posedge i_clock);
        rdchk("shift empty", ADDR_TX_STATUS, 8'h32);
        wr(ADDR_TX_STATUS, 8'h71);
        wr(ADDR_TX_BUFFER, 8'h3C);
        mst_u.frame(9, 9'h000, got);
        check("nine bit tx", got, 9'h13C);
        wr(ADDR_TX_STATUS, 8'h10);
        wr(ADDR_RX_STATUS, 8'hA0);
        wr(ADDR_IRQ_CTRL, 8'hE0);
        mst_u.frame(8, 9'h0C3, got);
        repeat (6) @(posedge i_clock);
        rdchk("single rx", ADDR_IRQ_CTRL, 8'hE1);
        wr(ADDR_RX_STATUS, 8'hF0);
        mst_u.frame(9, 9'h1A5, got);
        repeat (6) @(posedge i_clock);
        check("wake rx", {8'h00, wake}, 9'h001);
        check("vector rx", {8'h00, irqv}, 9'h001);
        rdchk("rx status", ADDR_RX_STATUS, 8'hF1);
        rdchk("rx data", ADDR_RX_BUFFER, 8'hA5);
        rdchk("full cleared", ADDR_IRQ_CTRL, 8'hE1);
        wr(ADDR_IRQ_CTRL, 8'hC0);
        mst_u.frame(9, 9'h1FF, got);
        mst_u.frame(9, 9'h055, got);
        repeat (6) @(posedge i_clock);
        check("no rx vector", {8'h00, irqv}, 9'h000);
        rdchk("overrun", ADDR_RX_STATUS, 8'hF3);
        rdchk("kept data", ADDR_RX_BUFFER, 8'hFF);
        wr(ADDR_RX_STATUS, 8'hE0);
        rdchk("err cleared", ADDR_RX_STATUS, 8'hE1);
        wr(ADDR_RX_STATUS, 8'h90);
        mst_u.frame(8, 9'h081, got);
        repeat (6) @(posedge i_clock);
        rdchk("eight bit rx", ADDR_RX_BUFFER, 8'h81);
        report_and_stop();
    end
endmodule : tb_top
